// ### mta_pkg.sv
package mta_pkg;

  // ************************************************************
  // Array windows, decoded on the upper address bits
  // ************************************************************
  localparam logic [7:0] MTA_IADDR_SEL  = 8'hf2;   // Bits 31:24, instruction address array
  localparam logic [8:0] MTA_IDATA1_SEL = 9'h1e6;  // Bits 31:23, i.e. F30 window
  localparam logic [8:0] MTA_IDATA2_SEL = 9'h1e7;  // Bits 31:23, i.e. F38 window
  localparam logic [7:0] MTA_UADDR_SEL  = 8'hf6;   // Bits 31:24, unified address array

  // Window base byte addresses
  localparam logic [31:0] MTA_INSTR_XLAT_ADDRESS_ARRAY    = 32'hf2000000;
  localparam logic [31:0] MTA_INSTR_XLAT_DATA_ARRAY_ONE   = 32'hf3000000;
  localparam logic [31:0] MTA_INSTR_XLAT_DATA_ARRAY_TWO   = 32'hf3800000;
  localparam logic [31:0] MTA_UNIFIED_XLAT_ADDRESS_ARRAY  = 32'hf6000000;

  // ************************************************************
  // Sizes and field positions
  // ************************************************************
  localparam int MTA_I_ENTRIES = 4;    // Instruction buffer depth
  localparam int MTA_U_ENTRIES = 64;   // Unified buffer depth
  localparam int MTA_VPN_LSB   = 10;   // Page number low bit
  localparam int MTA_IDX_LSB   = 8;    // Entry index low address bit
  localparam int MTA_CMP_BIT   = 7;    // Compare-on-write address bit
  localparam int MTA_DIRTY_BIT = 9;    // Dirty flag in address word
  localparam int MTA_VALID_BIT = 8;    // Valid flag in all views except data array two

  // ************************************************************
  // Controller register map (byte offsets) and bits
  // ************************************************************
  localparam logic [4:0] MTA_REG_ADDR   = 5'h00;  // Target array address
  localparam logic [4:0] MTA_REG_WDATA  = 5'h04;  // Data to write
  localparam logic [4:0] MTA_REG_CTRL   = 5'h08;  // Bit0 start, bit1 write
  localparam logic [4:0] MTA_REG_STATUS = 5'h0c;  // Bit0 busy, bit1 done, bit2 error
  localparam logic [4:0] MTA_REG_RDATA  = 5'h10;  // Last read result
  localparam int MTA_CTRL_GO   = 0;
  localparam int MTA_CTRL_WR   = 1;
  localparam int MTA_ST_BUSY   = 0;
  localparam int MTA_ST_DONE   = 1;
  localparam int MTA_ST_ERR    = 2;
  localparam logic [1:0] MTA_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MTA_RESP_SLVERR = 2'h2;

endpackage

// ### mta_if.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Load/store path between core and translation arrays
// ************************************************************
interface mta_if;
  logic        req;       // Access request, held until ack
  logic        wr;        // High for write
  logic        fetch;     // High for instruction fetch
  logic        longword;  // High for 32-bit access
  logic [31:0] addr;      // Access address
  logic [31:0] wdata;     // Write data
  logic        ack;       // One-cycle completion
  logic        err;       // Access refused, valid with ack
  logic [31:0] rdata;     // Read data, valid with ack

  modport dev  (input req, wr, fetch, longword, addr, wdata, output ack, err, rdata);
  modport core (output req, wr, fetch, longword, addr, wdata, input ack, err, rdata);
endinterface

`default_nettype wire

// ### mta_array_dev.sv
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Array accesses only from uncached region code
// - Eight instructions before branching elsewhere
// - Longword only; no instruction fetches
// - Write reserved bits zero; reads undefined
// - Valid and dirty shared between views
// - F2 selects instruction address array, index 9:8
// - Requester drives address bits 1:0 zero
// - Instr address word: page, valid, tag
// - Instr address read/write these three fields
// - F30 selects instruction data array one
// - Data one field layout as listed
// - Data one read/write all its fields
// - F38 selects instruction data array two
// - Data two: space attribute, timing flag
// - F6 selects unified address array, index 13:8
// - Address bit 7 selects compare-on-write
// - Unified word: page, dirty, valid, tag
// - Unified read indexed, never associative
// - Plain write stores all fields indexed
// - Compare write updates single hit; multi-hit traps
// - Compare write also updates instruction valid
module mta_array_dev
  import mta_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Core side
  mta_if.dev              bus,
  // Current space tag from the page entry high register
  input  wire logic [7:0] i_cur_space_tag,
  // Exception
  output logic            o_multi_hit
);
  import mta_pkg::*;

  // ************************************************************
  // Entry storage
  // ************************************************************
  logic [21:0] i_vpn_q   [MTA_I_ENTRIES];  // Instr page numbers
  logic [7:0]  i_tag_q   [MTA_I_ENTRIES];  // Instr space tags
  logic        i_valid_q [MTA_I_ENTRIES];  // Shared by instr address and data one views
  logic [18:0] i_ppn_q   [MTA_I_ENTRIES];  // Physical page numbers
  logic [1:0]  i_size_q  [MTA_I_ENTRIES];  // Page size field
  logic        i_prot_q  [MTA_I_ENTRIES];  // Protection field
  logic        i_cache_q [MTA_I_ENTRIES];  // Cacheable
  logic        i_shr_q   [MTA_I_ENTRIES];  // Shared flag
  logic [2:0]  i_sa_q    [MTA_I_ENTRIES];  // Space attribute
  logic        i_tc_q    [MTA_I_ENTRIES];  // Timing control flag
  logic [21:0] u_vpn_q   [MTA_U_ENTRIES];  // Unified page numbers
  logic [7:0]  u_tag_q   [MTA_U_ENTRIES];  // Unified space tags
  logic        u_valid_q [MTA_U_ENTRIES];  // Single storage for valid
  logic        u_dirty_q [MTA_U_ENTRIES];  // Single storage for dirty

  // ************************************************************
  // Decode
  // ************************************************************
  logic        take;        // Request accepted this cycle
  logic        legal;       // Longword data access, aligned
  logic        sel_ia;      // Instr address array
  logic        sel_i1;      // Instr data array one
  logic        sel_i2;      // Instr data array two
  logic        sel_ua;      // Unified address array
  logic [1:0]  i_idx;       // Instr entry index
  logic [5:0]  u_idx;       // Unified entry index
  logic        assoc_wr;    // Compare-on-write access
  logic [21:0] wvpn;        // Page number from data word
  logic        ack_q;       // Response strobe
  logic        err_q;       // Response error
  logic [31:0] rdata_q;     // Response data
  logic        mhit_q;      // Multiple-hit pulse

  // Ack blocks a second take while the core still holds req
  assign take  = bus.req & ~ack_q;
  // Fetches and narrow or unaligned accesses are refused
  assign legal = bus.longword & ~bus.fetch & (bus.addr[1:0] == 2'h0);
  assign sel_ia = (bus.addr[31:24] == MTA_IADDR_SEL);
  assign sel_i1 = (bus.addr[31:23] == MTA_IDATA1_SEL);
  assign sel_i2 = (bus.addr[31:23] == MTA_IDATA2_SEL);
  assign sel_ua = (bus.addr[31:24] == MTA_UADDR_SEL);
  assign i_idx  = bus.addr[MTA_IDX_LSB+1:MTA_IDX_LSB];
  assign u_idx  = bus.addr[MTA_IDX_LSB+5:MTA_IDX_LSB];
  assign assoc_wr = bus.addr[MTA_CMP_BIT];
  assign wvpn   = bus.wdata[31:MTA_VPN_LSB];

  // ************************************************************
  // Associative compare
  // ************************************************************
  logic [MTA_U_ENTRIES-1:0] u_hit;  // Unified matches
  logic [MTA_I_ENTRIES-1:0] i_hit;  // Instr matches
  logic                     u_multi;
  logic                     u_any;
  logic                     do_assoc;

  // Page and current tag must both match a live entry
  genvar g;
  generate
    for (g = 0; g < MTA_U_ENTRIES; g++) begin : g_ucmp
      assign u_hit[g] = u_valid_q[g] & (u_vpn_q[g] == wvpn)
                        & (u_tag_q[g] == i_cur_space_tag);
    end
    for (g = 0; g < MTA_I_ENTRIES; g++) begin : g_icmp
      assign i_hit[g] = i_valid_q[g] & (i_vpn_q[g] == wvpn)
                        & (i_tag_q[g] == i_cur_space_tag);
    end
  endgenerate

  // More than one bit set means a multiple hit
  assign u_multi  = |(u_hit & (u_hit - 64'h1));
  assign u_any    = |u_hit;
  assign do_assoc = take & legal & sel_ua & bus.wr & assoc_wr;

  // ************************************************************
  // Instruction buffer writes
  // ************************************************************
  // Valid is one flop per entry, written from the address view, data one view or a compare write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < MTA_I_ENTRIES; k++) begin
        i_vpn_q[k]   <= 22'h0;
        i_tag_q[k]   <= 8'h0;
        i_valid_q[k] <= 1'b0;
        i_ppn_q[k]   <= 19'h0;
        i_size_q[k]  <= 2'h0;
        i_prot_q[k]  <= 1'b0;
        i_cache_q[k] <= 1'b0;
        i_shr_q[k]   <= 1'b0;
        i_sa_q[k]    <= 3'h0;
        i_tc_q[k]    <= 1'b0;
      end
    end else if (take && legal && bus.wr) begin
      if (sel_ia) begin
        // Address view write
        i_vpn_q[i_idx]   <= wvpn;
        i_valid_q[i_idx] <= bus.wdata[MTA_VALID_BIT];
        i_tag_q[i_idx]   <= bus.wdata[7:0];
      end else if (sel_i1) begin
        // Data one view write
        i_ppn_q[i_idx]   <= bus.wdata[28:10];
        i_valid_q[i_idx] <= bus.wdata[MTA_VALID_BIT];
        i_size_q[i_idx]  <= {bus.wdata[7], bus.wdata[4]};
        i_prot_q[i_idx]  <= bus.wdata[6];
        i_cache_q[i_idx] <= bus.wdata[3];
        i_shr_q[i_idx]   <= bus.wdata[1];
      end else if (sel_i2) begin
        // Data two view write
        i_sa_q[i_idx] <= bus.wdata[2:0];
        i_tc_q[i_idx] <= bus.wdata[3];
      end else if (sel_ua && assoc_wr) begin
        // Compare write reaches instr side even on unified miss
        for (int k = 0; k < MTA_I_ENTRIES; k++) begin
          if (i_hit[k]) begin
            i_valid_q[k] <= bus.wdata[MTA_VALID_BIT];
          end
        end
      end
    end
  end

  // ************************************************************
  // Unified buffer writes
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < MTA_U_ENTRIES; k++) begin
        u_vpn_q[k]   <= 22'h0;
        u_tag_q[k]   <= 8'h0;
        u_valid_q[k] <= 1'b0;
        u_dirty_q[k] <= 1'b0;
      end
    end else if (take && legal && bus.wr && sel_ua) begin
      if (!assoc_wr) begin
        // Plain indexed write
        u_vpn_q[u_idx]   <= wvpn;
        u_dirty_q[u_idx] <= bus.wdata[MTA_DIRTY_BIT];
        u_valid_q[u_idx] <= bus.wdata[MTA_VALID_BIT];
        u_tag_q[u_idx]   <= bus.wdata[7:0];
      end else if (u_any && !u_multi) begin
        // Single hit: only flags change; miss is a no-op
        for (int k = 0; k < MTA_U_ENTRIES; k++) begin
          if (u_hit[k]) begin
            u_dirty_q[k] <= bus.wdata[MTA_DIRTY_BIT];
            u_valid_q[k] <= bus.wdata[MTA_VALID_BIT];
          end
        end
      end
    end
  end

  // ************************************************************
  // Response
  // ************************************************************
  // Reserved bits return zero, which software must not rely on
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= take;
      if (take) begin
        err_q   <= ~legal | ~(sel_ia | sel_i1 | sel_i2 | sel_ua);
        rdata_q <= 32'h0;
        if (legal && !bus.wr) begin
          if (sel_ia) begin
            rdata_q <= {i_vpn_q[i_idx], 1'b0, i_valid_q[i_idx],
                        i_tag_q[i_idx]};
          end else if (sel_i1) begin
            rdata_q <= {3'h0, i_ppn_q[i_idx], 1'b0, i_valid_q[i_idx],
                        i_size_q[i_idx][1], i_prot_q[i_idx], 1'b0,
                        i_size_q[i_idx][0], i_cache_q[i_idx], 1'b0,
                        i_shr_q[i_idx], 1'b0};
          end else if (sel_i2) begin
            rdata_q <= {28'h0, i_tc_q[i_idx], i_sa_q[i_idx]};
          end else if (sel_ua) begin
            // Compare bit ignored on reads
            rdata_q <= {u_vpn_q[u_idx], u_dirty_q[u_idx],
                        u_valid_q[u_idx], u_tag_q[u_idx]};
          end
        end
      end
    end
  end

  // Multiple hit raised one cycle after the compare write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mhit_q <= 1'b0;
    end else begin
      mhit_q <= do_assoc & u_multi;
    end
  end

  assign bus.ack     = ack_q;
  assign bus.err     = err_q;
  assign bus.rdata   = rdata_q;
  assign o_multi_hit = mhit_q;

endmodule

`default_nettype wire

// ### mta_core_ctl.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Core-side requester driven from AXI4-Lite registers
// ************************************************************
module mta_core_ctl
  import mta_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // AXI4-Lite write address and data
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_awaddr,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  // AXI4-Lite write response
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  output logic [1:0]       o_s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  input  wire logic [31:0] i_s_axi_araddr,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  // Array side
  mta_if.core              bus
);
  import mta_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  logic        aw_got_q;   // Write address held
  logic [4:0]  aw_off_q;   // Held write offset
  logic        w_got_q;    // Write data held
  logic [31:0] w_dat_q;    // Held write data
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] tgt_addr_q;  // Array address
  logic [31:0] tgt_wdat_q;  // Array write data
  logic [31:0] res_q;       // Last read result
  logic        req_q;       // Request to arrays
  logic        wr_q;        // Direction of request
  logic        done_q;      // Sticky completion
  logic        err_q;       // Sticky refusal
  logic        do_wr;       // Register write this cycle
  logic        st_clr_done; // Software clears done
  logic        st_clr_err;  // Software clears error
  logic        start;       // Start accepted

  // ************************************************************
  // AXI write path
  // ************************************************************
  // Either channel may arrive first; each is held until both are in
  assign o_s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign o_s_axi_wready  = ~w_got_q & ~bvalid_q;
  assign do_wr = aw_got_q & w_got_q & ~bvalid_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_got_q <= 1'b0;
      aw_off_q <= 5'h0;
      w_got_q  <= 1'b0;
      w_dat_q  <= 32'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= MTA_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_off_q <= i_s_axi_awaddr[4:0];
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_got_q <= 1'b1;
        // Byte lanes without strobe write as zero
        for (int b = 0; b < 4; b++) begin
          w_dat_q[8*b +: 8] <= i_s_axi_wstrb[b] ? i_s_axi_wdata[8*b +: 8] : 8'h0;
        end
      end
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (aw_off_q > MTA_REG_RDATA) ? MTA_RESP_SLVERR : MTA_RESP_OKAY;
      end else if (bvalid_q && i_s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // AXI read path
  // ************************************************************
  assign o_s_axi_arready = ~rvalid_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= MTA_RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= MTA_RESP_OKAY;
      unique case (i_s_axi_araddr[4:0])
        MTA_REG_ADDR:   rdata_q <= tgt_addr_q;
        MTA_REG_WDATA:  rdata_q <= tgt_wdat_q;
        MTA_REG_CTRL:   rdata_q <= {30'h0, wr_q, 1'b0};
        MTA_REG_STATUS: rdata_q <= {29'h0, err_q, done_q, req_q};
        MTA_REG_RDATA:  rdata_q <= res_q;
        default: begin
          rdata_q <= 32'h0;
          rresp_q <= MTA_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && i_s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ************************************************************
  // Registers and request
  // ************************************************************
  assign start       = do_wr & (aw_off_q == MTA_REG_CTRL) & w_dat_q[MTA_CTRL_GO] & ~req_q;
  assign st_clr_done = do_wr & (aw_off_q == MTA_REG_STATUS) & w_dat_q[MTA_ST_DONE];
  assign st_clr_err  = do_wr & (aw_off_q == MTA_REG_STATUS) & w_dat_q[MTA_ST_ERR];

  // Address and data are frozen while a request is out
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tgt_addr_q <= 32'h0;
      tgt_wdat_q <= 32'h0;
      wr_q       <= 1'b0;
    end else if (do_wr && !req_q) begin
      if (aw_off_q == MTA_REG_ADDR) begin
        tgt_addr_q <= {w_dat_q[31:2], 2'h0};
      end
      if (aw_off_q == MTA_REG_WDATA) begin
        tgt_wdat_q <= w_dat_q;  // Reserved bits left to software
      end
      if (aw_off_q == MTA_REG_CTRL) begin
        wr_q <= w_dat_q[MTA_CTRL_WR];
      end
    end
  end

  // Request held until ack; completion set wins over software clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_q  <= 1'b0;
      done_q <= 1'b0;
      err_q  <= 1'b0;
      res_q  <= 32'h0;
    end else begin
      if (start) begin
        req_q <= 1'b1;
      end else if (bus.ack) begin
        req_q <= 1'b0;
      end
      if (bus.ack) begin
        done_q <= 1'b1;
        if (!wr_q) begin
          res_q <= bus.rdata;
        end
      end else if (st_clr_done) begin
        done_q <= 1'b0;
      end
      if (bus.ack && bus.err) begin
        err_q <= 1'b1;
      end else if (st_clr_err) begin
        err_q <= 1'b0;
      end
    end
  end

  // Data accesses only, always longword
  assign bus.req      = req_q;
  assign bus.wr       = wr_q;
  assign bus.fetch    = 1'b0;
  assign bus.longword = 1'b1;
  assign bus.addr     = tgt_addr_q;
  assign bus.wdata    = tgt_wdat_q;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp  = bresp_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata  = rdata_q;
  assign o_s_axi_rresp  = rresp_q;

endmodule

`default_nettype wire

// ### mta_link_props.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Array link checks, fed from the interface signals
// ************************************************************
module mta_link_props
  import mta_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  // Link signals
  input wire logic        req,
  input wire logic        wr,
  input wire logic        fetch,
  input wire logic        longword,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        ack,
  input wire logic        err,
  input wire logic [31:0] rdata
);
  logic hit_win;  // Address falls in one of the four windows
  assign hit_win = addr[31:24] == MTA_IADDR_SEL || addr[31:23] == MTA_IDATA1_SEL ||
                   addr[31:23] == MTA_IDATA2_SEL || addr[31:24] == MTA_UADDR_SEL;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_ack_next: assert property (req && !ack |=> ack)
    else $error("no answer one cycle after take");
  a_ack_pulse: assert property (ack |=> !ack) else $error("answer longer than one cycle");
  a_req_hold: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata))
    else $error("request changed before answer");
  a_req_drop: assert property (ack |=> !req) else $error("request kept after answer");
  a_long_only: assert property (req |-> longword && !fetch)
    else $error("non-longword or fetch request");
  a_low_bits_zero: assert property (req |-> addr[1:0] == 2'h0)
    else $error("address low bits not zero");
  a_refuse_win: assert property (req && !ack && !hit_win |=> ack && err)
    else $error("outside access not refused");
  a_accept_win: assert property (req && !ack && hit_win |=> !err)
    else $error("window access refused");
  a_err_rdata: assert property (ack && (err || wr) |-> rdata == 32'h0)
    else $error("read data not zero on write or error");
  a_two_resv: assert property (ack && !wr && addr[31:23] == MTA_IDATA2_SEL |-> rdata[31:4] == 28'h0)
    else $error("data array two reserved bits set");
endmodule
`default_nettype wire

// ### mapped_tlb_array_access_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
// ************************************************************
// Bench: AXI4-Lite master, both link ends, queued read checks
// ************************************************************
module mapped_tlb_array_access_tb_top;
  import mta_pkg::*;
  logic        i_clk = 1'b0, i_rst_n = 1'b0;                   // Clock, reset
  logic        aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;  // Master strobes
  logic [31:0] aw_a = 0, w_d = 0, ar_a = 0, r_dat, v, d, ix;  // Payloads, scratch
  logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, mh;
  logic [1:0]  b_rsp, r_rsp, bq[$], be, lq[$], le;             // Responses and their notes
  logic [7:0]  tag = 8'h5a;                                    // Current space tag
  logic [33:0] exp_q[$], e;                                    // Expected {rresp, rdata}
  int          errors = 0, checked = 0, acks = 0;
  const logic [31:0] F2 = MTA_INSTR_XLAT_ADDRESS_ARRAY, U = MTA_UNIFIED_XLAT_ADDRESS_ARRAY;
  always #50 i_clk = ~i_clk;
  mta_if bus();
  mta_array_dev i_mta_array_dev (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus),
    .i_cur_space_tag(tag), .o_multi_hit(mh));
  mta_core_ctl i_mta_core_ctl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_s_axi_awvalid(aw_v),
    .o_s_axi_awready(aw_rdy), .i_s_axi_awaddr(aw_a), .i_s_axi_wvalid(w_v),
    .o_s_axi_wready(w_rdy), .i_s_axi_wdata(w_d), .i_s_axi_wstrb(4'hf),
    .o_s_axi_bvalid(b_vld), .i_s_axi_bready(b_r), .o_s_axi_bresp(b_rsp),
    .i_s_axi_arvalid(ar_v), .o_s_axi_arready(ar_rdy), .i_s_axi_araddr(ar_a),
    .o_s_axi_rvalid(r_vld), .i_s_axi_rready(r_r), .o_s_axi_rdata(r_dat),
    .o_s_axi_rresp(r_rsp), .bus(bus));
  mta_link_props i_mta_link_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .req(bus.req),
    .wr(bus.wr), .fetch(bus.fetch), .longword(bus.longword), .addr(bus.addr),
    .wdata(bus.wdata), .ack(bus.ack), .err(bus.err), .rdata(bus.rdata));
  // Read, write-response and link answers against oldest notes
  always @(posedge i_clk) begin
    if (r_vld && r_r) begin
      e = exp_q.pop_front();
      `CHK("read word", e, {r_rsp, r_dat})
    end
    if (b_vld && b_r) begin
      be = bq.pop_front();
      `CHK("write resp", be, b_rsp)
    end
    if (bus.ack) begin
      acks++;
      le = lq.pop_front();
      `CHK("link error", le[1], bus.err)
      `CHK("multi hit", le[0], mh)
    end
  end
  task automatic results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Write: both channels offered together, bready held until bvalid
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] dv,
                        input logic [1:0] er = MTA_RESP_OKAY);
    bq.push_back(er);
    @(posedge i_clk);
    aw_v <= 1'b1; aw_a <= {27'h0, a}; w_v <= 1'b1; w_d <= dv; b_r <= 1'b1;
    do begin
      @(posedge i_clk);
      if (aw_v && aw_rdy) aw_v <= 1'b0;
      if (w_v && w_rdy) w_v <= 1'b0;
    end while (!b_vld);
    b_r <= 1'b0;
  endtask
  task automatic axi_rd(input logic [4:0] a, input logic [33:0] ev);
    exp_q.push_back(ev);
    @(posedge i_clk);
    ar_v <= 1'b1; ar_a <= {27'h0, a}; r_r <= 1'b1;
    do begin
      @(posedge i_clk);
      if (ar_v && ar_rdy) ar_v <= 1'b0;
    end while (!r_vld);
    r_r <= 1'b0;
  endtask
  // One data move at a time, never a fetch
  task automatic op(input logic [31:0] a, dv, input logic w, e_err, e_mh);
    int n;
    lq.push_back({e_err, e_mh});
    axi_wr(MTA_REG_ADDR, a);
    axi_wr(MTA_REG_WDATA, dv);
    n = acks;
    axi_wr(MTA_REG_CTRL, {30'h0, w, 1'b1});
    do @(posedge i_clk); while (acks == n);
  endtask
  task automatic chk_rd(input logic [31:0] a, ev);
    op(a, 32'h0, 1'b0, 1'b0, 1'b0);
    axi_rd(MTA_REG_RDATA, {MTA_RESP_OKAY, ev});
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    results;
  end
  initial begin
    void'($urandom(32'h2292));
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < MTA_I_ENTRIES; i++) begin
      ix = 32'(i) << 8;
      v = ($urandom() & 32'hfffffdff) | 32'h100;
      op(F2 | ix, v, 1'b1, 1'b0, 1'b0);
      chk_rd(F2 | ix, v);
      d = $urandom() & 32'h1ffffcda;
      op(MTA_INSTR_XLAT_DATA_ARRAY_ONE | ix, d, 1'b1, 1'b0, 1'b0);
      chk_rd(MTA_INSTR_XLAT_DATA_ARRAY_ONE | ix, d);
      chk_rd(F2 | ix, v & ~32'h100);
      d = $urandom() & 32'hf;
      op(MTA_INSTR_XLAT_DATA_ARRAY_TWO | ix, d, 1'b1, 1'b0, 1'b0);
      chk_rd(MTA_INSTR_XLAT_DATA_ARRAY_TWO | ix, d);
    end
    $display("instruction arrays done");
    for (int i = 0; i < 4; i++) begin
      ix = (i == 0) ? 32'h3f00 : 32'($urandom_range(63)) << 8;
      v = $urandom();
      op(U | ix, v, 1'b1, 1'b0, 1'b0);
      chk_rd(U | ix | 32'h80, v);
    end
    $display("unified indexed done");
    v = {22'h2aaa5, 2'h1, tag};
    op(U | 32'h100, v, 1'b1, 1'b0, 1'b0);
    op(U | 32'h200, v, 1'b1, 1'b0, 1'b0);
    op(U | 32'h80, {22'h2aaa5, 2'h2, 8'h0}, 1'b1, 1'b0, 1'b1);
    chk_rd(U | 32'h100, v);
    v = {22'h1234, 2'h1, tag};
    op(U | 32'h300, v, 1'b1, 1'b0, 1'b0);
    op(F2, v, 1'b1, 1'b0, 1'b0);
    op(U | 32'h80, {22'h1234, 2'h2, 8'h0}, 1'b1, 1'b0, 1'b0);
    chk_rd(U | 32'h300, {22'h1234, 2'h2, tag});
    chk_rd(F2, {22'h1234, 2'h0, tag});
    op(U | 32'h80, {22'h3ffff0, 2'h3, 8'h0}, 1'b1, 1'b0, 1'b0);
    tag <= 8'h3c;
    op(U | 32'h80, {22'h2aaa5, 2'h2, 8'h0}, 1'b1, 1'b0, 1'b0);
    chk_rd(U | 32'h200, {22'h2aaa5, 2'h1, 8'h5a});
    $display("compare writes done");
    op(32'hf4000000, $urandom(), 1'b1, 1'b1, 1'b0);
    axi_wr(5'h14, $urandom(), MTA_RESP_SLVERR);
    axi_rd(5'h14, {MTA_RESP_SLVERR, 32'h0});
    axi_rd(MTA_REG_STATUS, {MTA_RESP_OKAY, 32'h6});
    axi_wr(MTA_REG_STATUS, 32'h6);
    axi_rd(MTA_REG_STATUS, {MTA_RESP_OKAY, 32'h0});
    $display("refusals done");
    repeat (2) @(posedge i_clk);
    results;
  end
endmodule
`default_nettype wire
